// File: rtl/pfc_defs.vh
// Constants for the parallel flash host controller
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
// Bus timing figures in ns, clock period in ns
`define PFC_CLK_NS          100
`define PFC_ACCESS_NS       120
`define PFC_WRPULSE_NS      50
`define PFC_RESET_PULSE_NS  500
`define PFC_RESET_HIGH_NS   50
`define PFC_SLEEP_EXTRA_NS  30
// Derived cycle counts: least times round up
`define PFC_ACCESS_CYC      ((`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_WRPULSE_CYC     ((`PFC_WRPULSE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RESET_CYC       ((`PFC_RESET_PULSE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_RESET_HIGH_CYC  ((`PFC_RESET_HIGH_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
// Request kinds
`define PFC_OP_READ         2'h0
`define PFC_OP_WRITE        2'h1
`define PFC_OP_RESET        2'h2
// Pin widths and phase timer width
`define PFC_ADDR_W          21
`define PFC_DATA_W          16
`define PFC_CNT_W           4
`endif

// File: rtl/pfc_host.v
// Host controller that drives a parallel NOR flash through its pins
`include "pfc_defs.vh"
module pfc_host
(
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst_n,
  // User request
  input  wire        i_req_valid,
  input  wire [1:0]  i_req_op,
  input  wire [21:0] i_req_addr,
  input  wire [15:0] i_req_wdata,
  input  wire        i_req_word,
  input  wire        i_req_accel,
  output wire        o_req_ready,
  // User answer
  output reg         o_rsp_valid,
  output reg  [15:0] o_rsp_rdata,
  output reg         o_restart_needed,
  // Flash control pins
  output reg         o_chip_sel_n,
  output reg         o_out_en_n,
  output reg         o_wr_en_n,
  output reg         o_reset_n,
  output reg         o_word_mode,
  output reg         o_accel_high,
  output reg  [20:0] o_addr,
  // Flash data pins
  input  wire [15:0] i_dq,
  output reg  [15:0] o_dq,
  output reg  [15:0] o_dq_oe_n,
  // Flash status
  input  wire        i_ready_busy_n
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_RDACC = 3'h1;
  localparam [2:0] ST_WRSET = 3'h2;
  localparam [2:0] ST_WRPUL = 3'h3;
  localparam [2:0] ST_RSTLO = 3'h4;
  localparam [2:0] ST_RSTWT = 3'h5;
  localparam [2:0] ST_RSTHI = 3'h6;

  // Phase lengths kept wide here, cut to the timer width where loaded
  localparam [31:0] ACC_CYC  = `PFC_ACCESS_CYC;
  localparam [31:0] WRP_CYC  = `PFC_WRPULSE_CYC;
  localparam [31:0] RLO_CYC  = `PFC_RESET_CYC;
  localparam [31:0] RHI_CYC  = `PFC_RESET_HIGH_CYC;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         tload;
  reg  [3:0]  tcount;
  reg         busy_at_reset_q;
  wire        tdone;

  // Phase timer kept apart so every timed phase shares one counter
  pfc_timer u_timer
  (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_load  (tload),
    .i_count (tcount),
    .o_done  (tdone)
  );

  // Data drive pattern; in byte mode DQ15 carries the low address bit
  function [15:0] drive_mask;
    input word;
    begin
      drive_mask = word ? 16'hFFFF : 16'h80FF;
    end
  endfunction

  assign o_req_ready = (state_q == ST_IDLE);

  // Next state and phase timer loads
  always @*
  begin
    state_d = state_q;
    tload   = 1'b0;
    tcount  = 4'h0;
    case (state_q)
      ST_IDLE:
        if (i_req_valid)
        begin
          tload = 1'b1;
          case (i_req_op)
            `PFC_OP_READ:
            begin
              state_d = ST_RDACC;
              tcount  = ACC_CYC[3:0];
            end
            `PFC_OP_WRITE:
            begin
              state_d = ST_WRSET;
              tcount  = 4'h1;
            end
            default:
            begin
              state_d = ST_RSTLO;
              tcount  = RLO_CYC[3:0];
            end
          endcase
        end
      ST_RDACC:
        if (tdone)
          state_d = ST_IDLE;
      ST_WRSET:
      begin
        state_d = ST_WRPUL;
        tload   = 1'b1;
        tcount  = WRP_CYC[3:0];
      end
      ST_WRPUL:
        if (tdone)
          state_d = ST_IDLE;
      ST_RSTLO:
        if (tdone)
          state_d = ST_RSTWT;
      // Wait for the device to leave its busy state before lifting reset
      ST_RSTWT:
        if (i_ready_busy_n)
        begin
          state_d = ST_RSTHI;
          tload   = 1'b1;
          tcount  = RHI_CYC[3:0];
        end
      ST_RSTHI:
        if (tdone)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Pin drive and answer registers
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      state_q          <= ST_IDLE;
      o_chip_sel_n     <= 1'b1;
      o_out_en_n       <= 1'b1;
      o_wr_en_n        <= 1'b1;
      o_reset_n        <= 1'b1;
      o_word_mode      <= 1'b1;
      o_accel_high     <= 1'b0;
      o_addr           <= 21'h00000;
      o_dq             <= 16'h0000;
      o_dq_oe_n        <= 16'hFFFF;
      o_rsp_valid      <= 1'b0;
      o_rsp_rdata      <= 16'h0000;
      o_restart_needed <= 1'b0;
      busy_at_reset_q  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      o_rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // Bus parked: deselected and floated, device drops to standby
          o_chip_sel_n <= 1'b1;
          o_out_en_n   <= 1'b1;
          o_wr_en_n    <= 1'b1;
          o_dq_oe_n    <= 16'hFFFF;
          o_accel_high <= 1'b0;
          if (i_req_valid)
          begin
            o_word_mode <= i_req_word;
            o_addr      <= i_req_word ? i_req_addr[20:0] : i_req_addr[21:1];
            o_dq        <= i_req_word ? i_req_wdata : {i_req_addr[0], 7'h00, i_req_wdata[7:0]};
            if (i_req_op == `PFC_OP_READ)
            begin
              o_chip_sel_n <= 1'b0;
              o_out_en_n   <= 1'b0;
              o_dq_oe_n    <= i_req_word ? 16'hFFFF : 16'h7FFF;
            end
            else if (i_req_op == `PFC_OP_WRITE)
            begin
              // Address and data set up one cycle ahead of write enable
              o_chip_sel_n <= 1'b0;
              o_dq_oe_n    <= ~drive_mask(i_req_word);
              o_accel_high <= i_req_accel;
            end
            else
            begin
              busy_at_reset_q <= ~i_ready_busy_n;
              o_reset_n       <= 1'b0;
            end
          end
        end
        ST_RDACC:
          if (tdone)
          begin
            // Sample once access time has passed; sleep keeps data held
            o_rsp_valid  <= 1'b1;
            o_rsp_rdata  <= o_word_mode ? i_dq : {8'h00, i_dq[7:0]};
            o_chip_sel_n <= 1'b1;
            o_out_en_n   <= 1'b1;
          end
        ST_WRSET:
          o_wr_en_n <= 1'b0;
        ST_WRPUL:
          if (tdone)
          begin
            // Release: device latches data on rising edge, may run on deselected
            o_wr_en_n    <= 1'b1;
            o_chip_sel_n <= 1'b1;
            o_rsp_valid  <= 1'b1;
          end
        ST_RSTHI:
          if (tdone)
          begin
            o_rsp_valid      <= 1'b1;
            o_restart_needed <= busy_at_reset_q;
          end
        default:
          if (state_q == ST_RSTWT && i_ready_busy_n)
            o_reset_n <= 1'b1;
      endcase
    end
  end
endmodule

// File: rtl/pfc_timer.v
// Down counter that times one phase of a flash bus cycle
module pfc_timer
(
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst_n,
  // Control
  input  wire        i_load,
  input  wire [3:0]  i_count,
  // Status
  output wire        o_done
);
  reg [3:0] cnt_q;

  // Load wins over counting so a phase starts clean
  always @(posedge i_clock)
  begin
    if (!i_rst_n)
      cnt_q <= 4'h0;
    else if (i_load)
      cnt_q <= i_count;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end

  assign o_done = (cnt_q == 4'h0) && !i_load;
endmodule

// File: sim/pfc_flash_model.sv
// Behavioural flash device at the far side of the host pins
module pfc_flash_model
(
  // Clock
  input  wire         i_clock,
  // Pins from the host
  input  wire         i_chip_sel_n,
  input  wire         i_out_en_n,
  input  wire         i_wr_en_n,
  input  wire         i_reset_n,
  input  wire         i_word_mode,
  input  wire  [20:0] i_addr,
  input  wire  [15:0] i_dq,
  // Device answer
  output logic [15:0] o_dq,
  output logic        o_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [5:0]  busy_q = 6'h00;
  logic        tog_q = 1'b0;
  wire  [15:0] word_d = mem[i_addr[7:0]];
  // Array readable at once after power up
  initial for (int i = 0; i < 256; i++) mem[i] = 16'hC3A5 ^ (16'(i) * 16'h0101);
  // Released lines wander so stale data never passes
  always_comb
  begin
    o_dq = 16'h5A5A ^ {16{tog_q}};
    if (!i_chip_sel_n && !i_out_en_n && i_reset_n)
      if (i_word_mode) o_dq = word_d;
      else o_dq[7:0] = i_dq[15] ? word_d[15:8] : word_d[7:0];
  end
  // Writes latch only when selected and out of reset; busy counts down regardless, cut to 8 while in reset
  always @(posedge i_clock)
  begin
    tog_q <= !tog_q;
    busy_q <= (!i_reset_n && busy_q > 6'h08) ? 6'h08 : busy_q - {5'h00, busy_q != 6'h00};
    if (!i_wr_en_n && !i_chip_sel_n && i_reset_n)
    begin
      busy_q <= 6'h14;
      if (i_word_mode) mem[i_addr[7:0]] <= i_dq;
      else if (i_dq[15]) mem[i_addr[7:0]][15:8] <= i_dq[7:0];
      else mem[i_addr[7:0]][7:0] <= i_dq[7:0];
    end
  end
  assign o_ready_busy_n = (busy_q == 6'h00);
endmodule

// File: sim/pfc_host_asserts.sv
// Pin protocol checker for the flash host controller
module pfc_host_asserts
(
  // Clock, reset and request
  input wire        i_clock,
  input wire        i_rst_n,
  input wire        i_req_valid,
  input wire [1:0]  i_req_op,
  input wire        o_req_ready,
  input wire        o_rsp_valid,
  // Flash pins
  input wire        o_chip_sel_n,
  input wire        o_out_en_n,
  input wire        o_wr_en_n,
  input wire        o_reset_n,
  input wire        o_word_mode,
  input wire        o_accel_high,
  input wire [15:0] o_dq_oe_n,
  input wire        i_ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Request accepted this edge
  wire take = i_req_valid && o_req_ready;
  AST_READ_PINS: assert property (!o_out_en_n |-> o_wr_en_n && !o_chip_sel_n && o_dq_oe_n[14:0] == 15'h7FFF)
    else $error("read pin levels wrong");
  AST_WRITE_PINS: assert property (!o_wr_en_n |-> !o_chip_sel_n && o_out_en_n && o_dq_oe_n[7:0] == 8'h00)
    else $error("write pin levels wrong");
  AST_ACCEL_WRITE: assert property (o_accel_high |-> o_out_en_n && o_reset_n)
    else $error("high voltage outside a write");
  AST_READ_TIME: assert property (take && i_req_op == 2'h0 |-> ##4 o_rsp_valid)
    else $error("read answer late");
  AST_WRITE_TIME: assert property (take && i_req_op == 2'h1 |-> ##[3:4] o_rsp_valid)
    else $error("write answer late");
  AST_RESET_HOLD: assert property ($fell(o_reset_n) |-> !o_reset_n [*5])
    else $error("reset pulse too short");
  AST_RESET_WAIT: assert property (!o_reset_n && !i_ready_busy_n |=> !o_reset_n)
    else $error("reset released while busy");
  AST_BYTE_LSB: assert property (!o_word_mode && !o_out_en_n |-> !o_dq_oe_n[15])
    else $error("low address bit not driven");
  AST_WORD_DQ15: assert property (o_word_mode && !o_out_en_n |-> o_dq_oe_n[15])
    else $error("top data line driven in read");
  // Main scenarios reached
  COV_RESET: cover property (take && i_req_op == 2'h2);
  COV_ACCEL: cover property (o_accel_high && !o_wr_en_n);
  COV_BYTE: cover property (!o_word_mode && !o_out_en_n);
endmodule
bind pfc_host pfc_host_asserts u_chk (.*);

// File: sim/test_pfc_host.sv
// Self-checking bench for the parallel flash host controller
module test_pfc_host;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, iv = 0, iw = 1, ia = 0;
  logic [1:0]  iop = 0;
  logic [21:0] iad = 0;
  logic [15:0] iwd = 0, e, shadow [256];
  logic [17:0] q [$], n;
  int          err_total = 0, n_checks = 0;
  wire         rdy, rv, rn, cs_n, oe_n, we_n, rs_n, wm, rb_n, acc;
  wire  [15:0] rd, h_dq, h_oe_n, m_dq, dq;
  wire  [20:0] ad;
  // Wire level: host bits where it drives, device elsewhere
  assign dq = (~h_oe_n & h_dq) | (h_oe_n & m_dq);
  always #50 clk = ~clk;
  pfc_host dut (.i_clock(clk), .i_rst_n(rst_n), .i_req_valid(iv), .i_req_op(iop), .i_req_addr(iad),
    .i_req_wdata(iwd), .i_req_word(iw), .i_req_accel(ia), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(rd), .o_restart_needed(rn), .o_chip_sel_n(cs_n), .o_out_en_n(oe_n), .o_wr_en_n(we_n),
    .o_reset_n(rs_n), .o_word_mode(wm), .o_accel_high(acc), .o_addr(ad), .i_dq(dq), .o_dq(h_dq),
    .o_dq_oe_n(h_oe_n), .i_ready_busy_n(rb_n));
  pfc_flash_model u_flash (.i_clock(clk), .i_chip_sel_n(cs_n), .i_out_en_n(oe_n), .i_wr_en_n(we_n),
    .i_reset_n(rs_n), .i_word_mode(wm), .i_addr(ad), .i_dq(dq), .o_dq(m_dq), .o_ready_busy_n(rb_n));
  task automatic chk(input string nm, input [15:0] ex, input [15:0] got);
    n_checks++;
    if (got !== ex)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One request; expected read data noted for the monitor
  task automatic req(input [1:0] op, input [21:0] a, input [15:0] d, input w, input ac);
    logic [7:0] x;
    x = w ? a[7:0] : a[8:1];
    e = w ? shadow[x] : {8'h00, a[0] ? shadow[x][15:8] : shadow[x][7:0]};
    if (op == 2'h1 && w) shadow[x] = d;
    else if (op == 2'h1 && a[0]) shadow[x][15:8] = d[7:0];
    else if (op == 2'h1) shadow[x][7:0] = d[7:0];
    q.push_back({op == 2'h0, op == 2'h1 && ac, e});
    {iv, iop, iad, iwd, iw, ia} <= {1'b1, op, a, d, w, ac};
    @(posedge clk);
    while (!rdy) @(posedge clk);
    iv <= 0;
    repeat (300) if (rv !== 1'b1) @(posedge clk);
    // A missing answer counts against the run
    chk("rsp_valid", 16'h0001, {15'h0000, rv});
  endtask
  // Monitor pairs each answer with the oldest note
  always @(posedge clk)
    if (rv === 1'b1 && q.size() > 0)
    begin
      n = q.pop_front();
      if (n[17]) chk("rdata", n[15:0], rd);
      chk("accel", {15'h0000, n[16]}, {15'h0000, acc});
    end
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h11c6));
    for (int i = 0; i < 256; i++) shadow[i] = 16'hC3A5 ^ (16'(i) * 16'h0101);
    repeat (4) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) req(0, 22'($urandom % 256), 0, 1, 0);
    for (int i = 0; i < 6; i++) req(1, 22'(i), 16'($urandom), i < 3, i[0]);
    for (int i = 0; i < 3; i++) req(0, 22'(i), 0, 1, 0);
    for (int i = 0; i < 6; i++) req(0, 22'(i), 0, 0, 0);
    req(1, 22'h40, 16'($urandom), 1, 0);
    req(2, 0, 0, 1, 0);
    chk("restart", 16'h0001, {15'h0000, rn});
    req(2, 0, 0, 1, 0);
    chk("restart", 16'h0000, {15'h0000, rn});
    req(0, 22'h40, 0, 1, 0);
    close_out;
  end
  initial
  begin
    #2000000;
    err_total++;
    close_out;
  end
endmodule
